// ---- ubc_pkg.sv ----
// Constants shared by the baud clock selector and its testbench.
// Assumes a 250 MHz machine clock and a 32-bit AHB-Lite register bus.
package ubc_pkg;

  // ****************************************************
  // Register offsets (byte addresses)
  // ****************************************************
  localparam logic [7:0] UBC_OFF_MODE = 8'h00;
  localparam logic [7:0] UBC_OFF_PRESC = 8'h04;
  localparam logic [7:0] UBC_OFF_TMRCTL = 8'h08;
  localparam logic [7:0] UBC_OFF_RELOAD = 8'h0C;
  localparam logic [7:0] UBC_OFF_STATUS = 8'h10;
  localparam logic [7:0] UBC_OFF_TICKS = 8'h14;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int UBC_MODE_SRC_LSB = 0;
  localparam int UBC_MODE_OP_LSB = 3;
  localparam int UBC_MODE_DIR_BIT = 5;
  localparam int UBC_PRESC_DIV_LSB = 0;
  localparam int UBC_PRESC_EN_BIT = 7;
  localparam int UBC_TMR_CSEL_LSB = 0;
  localparam int UBC_TMR_EN_BIT = 2;
  localparam int UBC_STAT_LVL_BIT = 16;
  localparam int UBC_STAT_FAST_BIT = 17;
  localparam int UBC_STAT_ACT_BIT = 18;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [2:0] UBC_RST_SRC = 3'h0;
  localparam logic [1:0] UBC_RST_OP = 2'h0;
  localparam logic [3:0] UBC_RST_DIV = 4'hF;
  localparam logic [1:0] UBC_RST_CSEL = 2'h0;
  localparam logic [15:0] UBC_RST_RELOAD = 16'h0000;

  // ****************************************************
  // Source select codes and operating modes
  // ****************************************************
  localparam logic [2:0] UBC_SRC_GEN_MAX = 3'h4;
  localparam logic [2:0] UBC_SRC_RSVD = 3'h5;
  localparam logic [2:0] UBC_SRC_TIMER = 3'h6;
  localparam logic [2:0] UBC_SRC_EXT = 3'h7;
  localparam logic [1:0] UBC_OP_SYNC = 2'h2;
  localparam logic [3:0] UBC_DIV_MIN_CODE = 4'h8;
  localparam logic [3:0] UBC_DIV_OFF_CODE = 4'hF;

  // ****************************************************
  // Divide counts
  // ****************************************************
  localparam logic [4:0] UBC_PRESC_BASE = 5'h10;
  localparam logic [10:0] UBC_ASYNC_BASE = 11'h068;
  localparam logic [10:0] UBC_ASYNC_CODE4 = 11'h040;
  localparam logic [10:0] UBC_SYNC_BASE = 11'h002;
  localparam logic [5:0] UBC_X_DIV2 = 6'h02;
  localparam logic [5:0] UBC_X_DIV8 = 6'h08;
  localparam logic [5:0] UBC_X_DIV32 = 6'h20;
  localparam logic [5:0] UBC_UNDF_SYNC = 6'h02;
  localparam logic [5:0] UBC_UNDF_ASYNC = 6'h20;
  localparam logic [4:0] UBC_EXT_SYNC = 5'h01;
  localparam logic [4:0] UBC_EXT_ASYNC = 5'h10;

  // ****************************************************
  // Timing: shortest legal external clock period
  // ****************************************************
  localparam int UBC_CLK_PERIOD_PS = 4000;
  localparam int UBC_EXT_MIN_PERIOD_NS = 500;
  localparam int UBC_EXT_MIN_CYC =
    (UBC_EXT_MIN_PERIOD_NS * 1000) / UBC_CLK_PERIOD_PS;

endpackage : ubc_pkg

// ---- ubc_div.sv ----
// Enable-driven counter divider: one output pulse per ratio input pulses.
// Assumes ratio is held stable between clear pulses; ratio 0 stops it.
`timescale 1ns/1ps
`default_nettype none
module ubc_div #(
  parameter int W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic tick_in,
  input wire logic [W-1:0] ratio,
  output logic tick_out
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } ubc_div_st_t;

  ubc_div_st_t q;
  ubc_div_st_t d;
  logic last;

  assign last = (ratio != '0) &&
    (q.cnt == W'(ratio - {{(W-1){1'b0}}, 1'b1}));
  assign tick_out = tick_in && last && !clear;

  always_comb begin
    d = q;
    if (clear || ratio == '0) begin
      d.cnt = '0;
    end else if (tick_in) begin
      d.cnt = last ? '0 : W'(q.cnt + {{(W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  a_div_range: assert property (@(posedge hclk) disable iff (!hresetn)
    (ratio != '0) |-> (q.cnt < ratio))
    else $error("divider count beyond ratio");

endmodule : ubc_div
`default_nettype wire

// ---- ubc_sel.sv ----
// UART baud clock selector: generator, reload timer or external pin.
// Assumes an AHB-Lite master at hclk; serial_clock_pin is asynchronous.
//
// Functional notes
// - Prescaler divides machine clock 2..8 by code
// - Prescaler ratio same in both modes
// - Sync generator divides by 2,4,8,16,32
// - Async generator divides 104x2..16, or 64
// - Code 110 selects reload timer underflow
// - Timer source divides underflow by 2 or 32
// - Timer count clock is 2, 8 or 32
// - Reload value spans full sixteen bits
// - Code 111 selects external clock pin
// - External source ratios fixed, not programmable
// - External: async divide 16, sync direct
// - Generator rate is prescaler then mode ratio
// - Modes 0,1,3 async; mode 2 synchronous
`timescale 1ns/1ps
`default_nettype none
module ubc_sel
  import ubc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic serial_clock_pin,
  output logic serial_clock_dir_sel,
  output logic baud_tick,
  output logic async_mode
);

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WRITE,
    PH_READ
  } ubc_phase_t;

  typedef struct packed {
    ubc_phase_t phase;
    logic [7:0] dp_addr;
    logic hreadyout;
    logic [31:0] hrdata;
    logic [2:0] src_sel;
    logic [1:0] op_mode;
    logic dir_sel;
    logic prescale_enable;
    logic [3:0] prescale_div;
    logic [1:0] timer_clk_sel;
    logic tmr_en;
    logic [15:0] reload;
    logic [15:0] tmr_cnt;
    logic sync1;
    logic sync2;
    logic sync3;
    logic [7:0] ext_gap;
    logic ext_fast;
    logic [15:0] tick_cnt;
    logic baud_tick;
    logic async_mode;
  } ubc_st_t;

  ubc_st_t q;
  ubc_st_t d;

  // ****************************************************
  // Decoders
  // ****************************************************
  function automatic logic is_async(input logic [1:0] mode);
    is_async = (mode != UBC_OP_SYNC);
  endfunction : is_async

  function automatic logic [3:0] presc_ratio(input logic en,
                                             input logic [3:0] code);
    if (en && code >= UBC_DIV_MIN_CODE && code != UBC_DIV_OFF_CODE) begin
      presc_ratio = 4'(UBC_PRESC_BASE - {1'b0, code});
    end else begin
      presc_ratio = 4'h0;
    end
  endfunction : presc_ratio

  function automatic logic [10:0] gen_ratio(input logic async_m,
                                            input logic [2:0] code);
    if (code > UBC_SRC_GEN_MAX) begin
      gen_ratio = 11'h000;
    end else if (!async_m) begin
      gen_ratio = 11'(UBC_SYNC_BASE << code);
    end else if (code == UBC_SRC_GEN_MAX) begin
      gen_ratio = UBC_ASYNC_CODE4;
    end else begin
      gen_ratio = 11'(UBC_ASYNC_BASE * (UBC_SYNC_BASE << code));
    end
  endfunction : gen_ratio

  // ****************************************************
  // Divider chain
  // ****************************************************
  logic async_now;
  logic cfg_wr;
  logic [3:0] pre_ratio;
  logic [10:0] st2_ratio;
  logic [5:0] x_ratio;
  logic [5:0] undf_ratio;
  logic [4:0] ext_ratio;
  logic pre_tick;
  logic gen_tick;
  logic x_tick;
  logic undf_tick;
  logic timer_underflow;
  logic ext_edge;
  logic ext_tick;
  logic sel_tick;

  assign async_now = is_async(q.op_mode);
  assign cfg_wr = (q.phase == PH_WRITE);
  // Same prescaler ratio whatever the mode
  assign pre_ratio = presc_ratio(q.prescale_enable, q.prescale_div);
  assign st2_ratio = gen_ratio(async_now, q.src_sel);
  assign undf_ratio = async_now ? UBC_UNDF_ASYNC : UBC_UNDF_SYNC;
  assign ext_ratio = async_now ? UBC_EXT_ASYNC : UBC_EXT_SYNC;
  assign ext_edge = q.sync2 && !q.sync3;
  assign timer_underflow = q.tmr_en && x_tick && (q.tmr_cnt == 16'h0000);

  always_comb begin
    case (q.timer_clk_sel)
      2'h0: x_ratio = UBC_X_DIV2;
      2'h1: x_ratio = UBC_X_DIV8;
      2'h2: x_ratio = UBC_X_DIV32;
      default: x_ratio = 6'h00;
    endcase
  end

  ubc_div #(.W(4)) u_presc (
    .hclk(hclk), .hresetn(hresetn), .clear(cfg_wr),
    .tick_in(1'b1), .ratio(pre_ratio), .tick_out(pre_tick));

  ubc_div #(.W(11)) u_gen (
    .hclk(hclk), .hresetn(hresetn), .clear(cfg_wr),
    .tick_in(pre_tick), .ratio(st2_ratio), .tick_out(gen_tick));

  ubc_div #(.W(6)) u_tmr_clk (
    .hclk(hclk), .hresetn(hresetn), .clear(cfg_wr || !q.tmr_en),
    .tick_in(1'b1), .ratio(x_ratio), .tick_out(x_tick));

  ubc_div #(.W(6)) u_undf (
    .hclk(hclk), .hresetn(hresetn), .clear(cfg_wr),
    .tick_in(timer_underflow), .ratio(undf_ratio), .tick_out(undf_tick));

  ubc_div #(.W(5)) u_ext (
    .hclk(hclk), .hresetn(hresetn), .clear(cfg_wr),
    .tick_in(ext_edge), .ratio(ext_ratio), .tick_out(ext_tick));

  always_comb begin
    case (q.src_sel)
      UBC_SRC_RSVD: sel_tick = 1'b0;
      UBC_SRC_TIMER: sel_tick = undf_tick;
      UBC_SRC_EXT: sel_tick = ext_tick;
      default: sel_tick = gen_tick;
    endcase
  end

  // ****************************************************
  // Register read view
  // ****************************************************
  function automatic logic [31:0] rd_word(input ubc_st_t s,
                                          input logic act);
    rd_word = 32'h0000_0000;
    case (s.dp_addr)
      UBC_OFF_MODE: begin
        rd_word[UBC_MODE_SRC_LSB +: 3] = s.src_sel;
        rd_word[UBC_MODE_OP_LSB +: 2] = s.op_mode;
        rd_word[UBC_MODE_DIR_BIT] = s.dir_sel;
      end
      UBC_OFF_PRESC: begin
        rd_word[UBC_PRESC_DIV_LSB +: 4] = s.prescale_div;
        rd_word[UBC_PRESC_EN_BIT] = s.prescale_enable;
      end
      UBC_OFF_TMRCTL: begin
        rd_word[UBC_TMR_CSEL_LSB +: 2] = s.timer_clk_sel;
        rd_word[UBC_TMR_EN_BIT] = s.tmr_en;
      end
      UBC_OFF_RELOAD: rd_word[15:0] = s.reload;
      UBC_OFF_STATUS: begin
        rd_word[15:0] = s.tmr_cnt;
        rd_word[UBC_STAT_LVL_BIT] = s.sync2;
        rd_word[UBC_STAT_FAST_BIT] = s.ext_fast;
        rd_word[UBC_STAT_ACT_BIT] = act;
      end
      UBC_OFF_TICKS: rd_word[15:0] = s.tick_cnt;
      default: rd_word = 32'h0000_0000;
    endcase
  endfunction : rd_word

  // ****************************************************
  // Next state
  // ****************************************************
  logic take;
  logic src_active;
  ubc_st_t look;

  assign take = hsel && htrans[1] && hready;
  assign src_active = (q.src_sel != UBC_SRC_RSVD) &&
    ((q.src_sel == UBC_SRC_EXT) || (q.src_sel == UBC_SRC_TIMER) ?
     ((q.src_sel == UBC_SRC_EXT) || q.tmr_en) : (pre_ratio != 4'h0));

  always_comb begin
    d = q;
    look = q;
    d.hreadyout = 1'b1;
    // Data phase of a write
    if (q.phase == PH_WRITE) begin
      case (q.dp_addr)
        UBC_OFF_MODE: begin
          d.src_sel = hwdata[UBC_MODE_SRC_LSB +: 3];
          d.op_mode = hwdata[UBC_MODE_OP_LSB +: 2];
          d.dir_sel = hwdata[UBC_MODE_DIR_BIT];
        end
        UBC_OFF_PRESC: begin
          d.prescale_div = hwdata[UBC_PRESC_DIV_LSB +: 4];
          d.prescale_enable = hwdata[UBC_PRESC_EN_BIT];
        end
        UBC_OFF_TMRCTL: begin
          d.timer_clk_sel = hwdata[UBC_TMR_CSEL_LSB +: 2];
          d.tmr_en = hwdata[UBC_TMR_EN_BIT];
        end
        UBC_OFF_RELOAD: d.reload = hwdata[15:0];
        default: d.reload = q.reload;
      endcase
    end
    // Address phase
    if (take) begin
      d.phase = hwrite ? PH_WRITE : PH_READ;
      d.dp_addr = {haddr[7:2], 2'b00};
      look.dp_addr = d.dp_addr;
      d.hrdata = hwrite ? 32'h0000_0000 : rd_word(look, src_active);
    end else begin
      d.phase = PH_IDLE;
    end
    // Reload timer down counter
    if (!q.tmr_en) begin
      d.tmr_cnt = q.reload;
    end else if (timer_underflow) begin
      d.tmr_cnt = q.reload;
    end else if (x_tick) begin
      d.tmr_cnt = 16'(q.tmr_cnt - 16'h0001);
    end
    // Pin synchroniser and edge history
    d.sync1 = serial_clock_pin;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    // Spacing monitor on the external clock
    if (ext_edge) begin
      d.ext_gap = 8'h00;
    end else if (q.ext_gap != 8'hFF) begin
      d.ext_gap = 8'(q.ext_gap + 8'h01);
    end
    // Read of status clears the flag; a new violation wins
    if (take && !hwrite && d.dp_addr == UBC_OFF_STATUS) begin
      d.ext_fast = 1'b0;
    end
    if (ext_edge && q.ext_gap < 8'(UBC_EXT_MIN_CYC - 1)) begin
      d.ext_fast = 1'b1;
    end
    d.baud_tick = sel_tick;
    d.async_mode = async_now;
    if (sel_tick) begin
      d.tick_cnt = 16'(q.tick_cnt + 16'h0001);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.phase <= PH_IDLE;
      q.hreadyout <= 1'b1;
      q.src_sel <= UBC_RST_SRC;
      q.op_mode <= UBC_RST_OP;
      q.prescale_div <= UBC_RST_DIV;
      q.timer_clk_sel <= UBC_RST_CSEL;
      q.reload <= UBC_RST_RELOAD;
      q.ext_gap <= 8'hFF;
      q.async_mode <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign hreadyout = q.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = q.hrdata;
  assign serial_clock_dir_sel = q.dir_sel;
  assign baud_tick = q.baud_tick;
  assign async_mode = q.async_mode;

  // ****************************************************
  // Checks
  // ****************************************************
  a_presc_two: assert property (@(posedge hclk)
    disable iff (!hresetn || cfg_wr)
    (pre_ratio == 4'h2 && pre_tick) |=> !pre_tick ##1 pre_tick)
    else $error("prescaler divide by 2 spacing wrong");

  a_presc_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.prescale_div == UBC_DIV_OFF_CODE || !q.prescale_enable)
    |-> !pre_tick)
    else $error("prescaler ran while disabled");

  a_sync_ratio: assert property (@(posedge hclk) disable iff (!hresetn)
    (!async_now && q.src_sel == 3'h3) |-> st2_ratio == 11'h010)
    else $error("synchronous ratio for code 011 not 16");

  a_async_ratio: assert property (@(posedge hclk) disable iff (!hresetn)
    (async_now && q.src_sel == 3'h0) |-> st2_ratio == 11'h0D0)
    else $error("asynchronous ratio for code 000 not 208");

  a_gen_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    gen_tick |-> pre_tick)
    else $error("generator tick without prescaler tick");

  a_tmr_reload: assert property (@(posedge hclk) disable iff (!hresetn)
    (timer_underflow && !cfg_wr) |=> q.tmr_cnt == $past(q.reload))
    else $error("timer did not reload on underflow");

  a_tmr_xclk: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.timer_clk_sel == 2'h1) |-> x_ratio == 6'h08)
    else $error("timer count clock not divide by 8");

  a_undf_async: assert property (@(posedge hclk) disable iff (!hresetn)
    async_now |-> undf_ratio == 6'h20)
    else $error("timer underflow not divided by 32");

  a_ext_sync: assert property (@(posedge hclk)
    disable iff (!hresetn || cfg_wr)
    (q.src_sel == UBC_SRC_EXT && !async_now && ext_edge)
    |=> q.baud_tick)
    else $error("external sync edge gave no tick");

  a_rsvd_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.src_sel == UBC_SRC_RSVD) ##1 (q.src_sel == UBC_SRC_RSVD)
    |-> !q.baud_tick)
    else $error("tick while reserved source selected");

  a_tick_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    q.baud_tick |=> !q.baud_tick)
    else $error("baud tick longer than one cycle");

endmodule : ubc_sel
`default_nettype wire

// ---- ubc_sel_tb_top.sv ----
// Self-checking bench for the baud clock selector, driven over AHB-Lite.
// Assumes the selector's own assertions sit in its design files.
`timescale 1ns/1ps
`default_nettype none
module ubc_sel_tb_top
  import ubc_pkg::*;
;
  // ****************************************************
  // Signals and design
  // ****************************************************
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic serial_clock_pin;
  logic serial_clock_dir_sel;
  logic baud_tick;
  logic async_mode;
  int n_fail;
  int comparisons;
  int n_ticks;
  int t0;

  ubc_sel dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .serial_clock_pin(serial_clock_pin),
    .serial_clock_dir_sel(serial_clock_dir_sel),
    .baud_tick(baud_tick),
    .async_mode(async_mode)
  );

  always #2 hclk = ~hclk;

  // Running count of baud ticks
  always @(posedge hclk) begin
    if (baud_tick === 1'b1) n_ticks <= n_ticks + 1;
  end

  // ****************************************************
  // Reporting
  // ****************************************************
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // ****************************************************
  // Bus and tick helpers
  // ****************************************************
  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 100);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input string what, input logic [7:0] a,
                    input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h00000000, r);
    check(what, r, exp);
  endtask : rd

  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (baud_tick !== 1'b1 && n < 20000);
    if (baud_tick !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
  endtask : wait_tick

  // Spacing of two ticks after the restart settles
  task automatic period(input string what, input logic [31:0] exp);
    int a;
    int b;
    wait_tick(a);
    wait_tick(b);
    check(what, 32'(b), exp);
  endtask : period

  task automatic gen(input logic [2:0] s, input logic [1:0] op,
                     input logic [3:0] dv, input int exp);
    wr(UBC_OFF_PRESC, {24'h000000, 1'b1, 3'h0, dv});
    wr(UBC_OFF_MODE, {26'h0000000, 1'b0, op, s});
    period("generator period", exp);
    check("async_mode", {31'h0, async_mode}, {31'h0, op != UBC_OP_SYNC});
  endtask : gen

  task automatic tmr(input logic [1:0] cs, input logic [1:0] op,
                     input logic [15:0] rl, input int exp);
    wr(UBC_OFF_RELOAD, {16'h0000, rl});
    wr(UBC_OFF_TMRCTL, {29'h00000000, 1'b1, cs});
    wr(UBC_OFF_MODE, {26'h0000000, 1'b0, op, UBC_SRC_TIMER});
    period("timer period", exp);
  endtask : tmr

  // Pin edges no faster than the 2 MHz ceiling
  task automatic ext_edges(input int k);
    repeat (k) begin
      serial_clock_pin <= 1'b1;
      repeat (75) @(posedge hclk);
      serial_clock_pin <= 1'b0;
      repeat (75) @(posedge hclk);
    end
  endtask : ext_edges

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    serial_clock_pin = 1'b0;
    n_fail = 0;
    comparisons = 0;
    n_ticks = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("reset async_mode", {31'h0, async_mode}, 32'h1);
    check("reset baud_tick", {31'h0, baud_tick}, 32'h0);
    check("reset dir_sel", {31'h0, serial_clock_dir_sel}, 32'h0);
    rd("mode reset", UBC_OFF_MODE, 32'h00000000);
    rd("presc reset", UBC_OFF_PRESC, 32'h0000000F);
    rd("timer reset", UBC_OFF_TMRCTL, 32'h00000000);
    rd("reload reset", UBC_OFF_RELOAD, 32'h00000000);
    wr(8'h1C, 32'hFFFFFFFF);
    rd("unmapped", 8'h1C, 32'h00000000);
    wr(UBC_OFF_RELOAD, 32'h0000FFFF);
    rd("reload width", UBC_OFF_RELOAD, 32'h0000FFFF);
    wr(UBC_OFF_MODE, 32'h00000020);
    repeat (2) @(posedge hclk);
    check("dir_sel", {31'h0, serial_clock_dir_sel}, 32'h1);
    // Code 1111 never programmed
    for (int c = 8; c <= 14; c++) begin
      gen(3'h0, 2'h2, 4'(c), (16 - c) * 2);
    end
    for (int s = 0; s <= 4; s++) begin
      gen(3'(s), 2'h2, 4'h8, 8 * (2 << s));
    end
    for (int s = 0; s <= 3; s++) begin
      gen(3'(s), 2'(s & 1), 4'hE, 2 * (208 << s));
    end
    gen(3'h4, 2'h1, 4'hE, 128);
    rd("mode readback", UBC_OFF_MODE, 32'h0000000C);
    gen(3'h4, 2'h3, 4'hE, 128);
    wr(UBC_OFF_MODE, {26'h0000000, 1'b0, UBC_OP_SYNC, UBC_SRC_RSVD});
    // Let a tick launched before the write be counted first
    @(posedge hclk);
    t0 = n_ticks;
    repeat (2000) @(posedge hclk);
    check("reserved ticks", 32'(n_ticks - t0), 32'h0);
    tmr(2'h0, 2'h2, 16'h0002, 12);
    tmr(2'h1, 2'h2, 16'h0000, 16);
    tmr(2'h2, 2'h2, 16'h0000, 64);
    tmr(2'h0, 2'h0, 16'h0002, 192);
    wr(UBC_OFF_TMRCTL, 32'h00000007);
    @(posedge hclk);
    t0 = n_ticks;
    repeat (500) @(posedge hclk);
    check("timer clk sel 3 ticks", 32'(n_ticks - t0), 32'h0);
    wr(UBC_OFF_MODE, 32'h00000017);
    repeat (2) @(posedge hclk);
    check("dir_sel clear", {31'h0, serial_clock_dir_sel}, 32'h0);
    t0 = n_ticks;
    ext_edges(4);
    check("ext sync ticks", 32'(n_ticks - t0), 32'h4);
    wr(UBC_OFF_PRESC, 32'h00000088);
    wr(UBC_OFF_MODE, {26'h0000000, 1'b0, 2'h0, UBC_SRC_EXT});
    t0 = n_ticks;
    ext_edges(32);
    check("ext async ticks", 32'(n_ticks - t0), 32'h2);
    // Timer off: count reloads one cycle after the enable drops
    wr(UBC_OFF_TMRCTL, 32'h00000000);
    @(posedge hclk);
    rd("status", UBC_OFF_STATUS, 32'h00040002);
    rd("tick count", UBC_OFF_TICKS, n_ticks & 32'h0000FFFF);
    check("hresp", {31'h0, hresp}, 32'h0);
    print_verdict();
  end

endmodule : ubc_sel_tb_top
`default_nettype wire
